// >>> design/misc_op_pkg.sv
/*
 * Constants for the second-group single-word operation unit: opcode bytes,
 * field positions and cycle counts.
 * Assumes instruction bit 0 (leftmost) is word bit 15 of instr_i.
 */
package misc_op_pkg;
    localparam int unsigned ACC_W   = 16;
    localparam int unsigned PC_W    = 12;
    localparam int unsigned LVL_N   = 8;
    localparam int unsigned LVL_W   = 3;
    // Opcode byte, instruction bits 0..7
    localparam logic [7:0] OPC_ROTATE   = 8'hF0;
    localparam logic [7:0] OPC_HALT     = 8'h79;
    localparam logic [7:0] OPC_SKIP_Z   = 8'h74;
    localparam logic [7:0] OPC_SKIP_NZ  = 8'hF4;
    localparam logic [7:0] OPC_SKIP_BIT = 8'hF5;
    localparam logic [7:0] OPC_SKIP_NOV = 8'h70;
    localparam logic [7:0] OPC_CMPL     = 8'h73;
    localparam logic [7:0] OPC_OUT      = 8'h71;
    localparam logic [7:0] OPC_IN       = 8'h7C;
    localparam logic [7:0] OPC_IRET     = 8'h7F;
    localparam logic [7:0] OPC_MASK     = 8'hFE;
    localparam logic [7:0] OPC_UNMASK   = 8'h7E;
    // Field positions in instr_i
    localparam int unsigned OPC_LSB   = 8;
    localparam int unsigned ADDR_LSB  = 4;
    localparam int unsigned FUNC_LSB  = 0;
    localparam int unsigned CNT_LSB   = 0;
    localparam int unsigned LVL_LSB   = 2;
    // Cycle counts
    localparam logic [1:0] IRET_EXTRA_CYC = 2'h3;
    localparam logic [2:0] IN_SETTLE_CYC  = 3'h4;
    // Reset values
    localparam logic [ACC_W-1:0] ACC_RST  = 16'h0000;
    localparam logic [PC_W-1:0]  PC_RST   = 12'h000;
    localparam logic [LVL_N-1:0] LVL_RST  = 8'h00;
endpackage : misc_op_pkg

// >>> design/misc_op_unit.sv
/*
 * Execute unit for rotate, halt, skips, complement, direct I/O and
 * interrupt return / mask / unmask.
 * Assumes the datapath presents acc_i, pc_i, ovf_i steady while an
 * instruction is in flight, and applies the write-back pulses it gets.
 */
`timescale 1ns/1ps
`default_nettype none
module misc_op_unit
    import misc_op_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             instr_valid_i,
    input  wire logic [15:0]      instr_i,
    input  wire logic [1:0]       ind_levels_i,
    input  wire logic [ACC_W-1:0] acc_i,
    input  wire logic [PC_W-1:0]  pc_i,
    input  wire logic             ovf_i,
    input  wire logic             run_i,
    input  wire logic             step_i,
    input  wire logic [LVL_N-1:0] irq_i,
    input  wire logic             int_ack_i,
    input  wire logic [LVL_W-1:0] int_ack_level_i,
    input  wire logic [ACC_W-1:0] io_data_bus_i,
    output logic                  ready_o,
    output logic                  done_o,
    output logic                  acc_wr_o,
    output logic [ACC_W-1:0]      acc_val_o,
    output logic                  pc_wr_o,
    output logic [PC_W-1:0]       pc_val_o,
    output logic                  ovf_wr_o,
    output logic                  ovf_val_o,
    output logic                  halted_o,
    output logic [3:0]            io_addr_o,
    output logic [3:0]            io_func_o,
    output logic [ACC_W-1:0]      io_data_bus_o,
    output logic                  io_data_bus_oe_o,
    output logic                  output_write_strobe_o,
    output logic                  input_read_strobe_o,
    output logic                  int_req_o,
    output logic                  int_mask_o,
    output logic [LVL_N-1:0]      level_release_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_IND, ST_EXEC, ST_IRET, ST_IN_WAIT, ST_IN_DROP, ST_HALT
    } state_t;

    // Left rotate by n places
    function automatic logic [ACC_W-1:0] rotl(input logic [ACC_W-1:0] v,
                                              input logic [3:0] n);
        logic [2*ACC_W-1:0] d;
        d = {v, v} << n;
        return d[2*ACC_W-1:ACC_W];
    endfunction : rotl

    // Bit select with bit 0 at the most significant end
    function automatic logic msb0_bit(input logic [ACC_W-1:0] v, input logic [3:0] b);
        return v[4'hF - b];
    endfunction : msb0_bit

    state_t             state_reg, state_next;
    logic [15:0]        ir_reg;
    logic [1:0]         ind_cnt_reg;
    logic [2:0]         wait_cnt_reg;
    logic               step_armed_reg;
    logic               mask_reg;
    logic [LVL_N-1:0]   pending_reg;
    logic [LVL_N-1:0]   active_reg;
    logic [ACC_W-1:0]   save_acc [LVL_N];
    logic [PC_W-1:0]    save_pc  [LVL_N];
    logic [LVL_N-1:0]   save_ovf;
    // Synchronisers for pins
    logic [ACC_W-1:0]   din_s1, din_s2;
    logic [LVL_N+1:0]   ctl_s1, ctl_s2;
    logic [1:0]         ctl_s3;

    // Decoded fields and conditions
    wire logic [7:0]       opc      = ir_reg[OPC_LSB +: 8];
    wire logic [3:0]       fld_n    = ir_reg[CNT_LSB +: 4];
    wire logic [LVL_W-1:0] fld_l    = ir_reg[LVL_LSB +: LVL_W];
    wire logic             exec     = (state_reg == ST_EXEC);
    wire logic             acc_zero = (acc_i == ACC_RST);
    wire logic             run_rise  = ctl_s2[LVL_N] & ~ctl_s3[0];
    wire logic             step_rise = ctl_s2[LVL_N+1] & ~ctl_s3[1];
    wire logic [LVL_N-1:0] irq_sync = ctl_s2[LVL_N-1:0];
    wire logic             is_skip  = (opc == OPC_SKIP_Z) || (opc == OPC_SKIP_NZ) ||
                                      (opc == OPC_SKIP_BIT) || (opc == OPC_SKIP_NOV);
    wire logic             skip_take =
        ((opc == OPC_SKIP_Z)   &&  acc_zero) ||
        ((opc == OPC_SKIP_NZ)  && !acc_zero) ||
        ((opc == OPC_SKIP_BIT) && msb0_bit(acc_i, fld_n)) ||
        ((opc == OPC_SKIP_NOV) && !ovf_i);
    wire logic [PC_W-1:0]  pc_step  = skip_take ? PC_W'(2) : PC_W'(1);
    wire logic             finish   = (exec && opc != OPC_HALT && opc != OPC_IN &&
                                       opc != OPC_IRET) ||
                                      (state_reg == ST_IRET && wait_cnt_reg == 3'h1) ||
                                      (state_reg == ST_IN_DROP);
    wire logic             to_halt  = (exec && opc == OPC_HALT) ||
                                      (finish && step_armed_reg);

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (instr_valid_i) begin
                    state_next = (ind_levels_i != 2'h0) ? ST_IND : ST_EXEC;
                end
            end
            ST_IND: begin
                if (ind_cnt_reg == 2'h1) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (opc == OPC_HALT) begin
                    state_next = ST_HALT;
                end else if (opc == OPC_IN) begin
                    state_next = ST_IN_WAIT;
                end else if (opc == OPC_IRET) begin
                    state_next = ST_IRET;
                end else begin
                    state_next = step_armed_reg ? ST_HALT : ST_IDLE;
                end
            end
            ST_IRET: begin
                if (wait_cnt_reg == 3'h1) begin
                    state_next = step_armed_reg ? ST_HALT : ST_IDLE;
                end
            end
            ST_IN_WAIT: begin
                if (wait_cnt_reg == 3'h1) begin
                    state_next = ST_IN_DROP;
                end
            end
            ST_IN_DROP: begin
                state_next = step_armed_reg ? ST_HALT : ST_IDLE;
            end
            ST_HALT: begin
                if (run_rise || step_rise) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Pin synchronisers, two stages before any use
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            din_s1 <= ACC_RST;
            din_s2 <= ACC_RST;
            ctl_s1 <= '0;
            ctl_s2 <= '0;
            ctl_s3 <= 2'h0;
        end else begin
            din_s1 <= io_data_bus_i;
            din_s2 <= din_s1;
            ctl_s1 <= {step_i, run_i, irq_i};
            ctl_s2 <= ctl_s1;
            ctl_s3 <= ctl_s2[LVL_N+1:LVL_N];
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg      <= ST_IDLE;
            ir_reg         <= 16'h0000;
            ind_cnt_reg    <= 2'h0;
            wait_cnt_reg   <= 3'h0;
            step_armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && instr_valid_i) begin
                ir_reg      <= instr_i;
                ind_cnt_reg <= ind_levels_i;
            end else if (state_reg == ST_IND) begin
                ind_cnt_reg <= ind_cnt_reg - 2'h1;
            end
            if (exec) begin
                wait_cnt_reg <= (opc == OPC_IN) ? IN_SETTLE_CYC : {1'b0, IRET_EXTRA_CYC};
            end else if (wait_cnt_reg != 3'h0) begin
                wait_cnt_reg <= wait_cnt_reg - 3'h1;
            end
            if (state_reg == ST_HALT) begin
                step_armed_reg <= step_rise && !run_rise;
            end else if (finish) begin
                step_armed_reg <= 1'b0;
            end
        end
    end

    // Write-back to accumulator, PC and overflow
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc_wr_o  <= 1'b0;
            acc_val_o <= ACC_RST;
            pc_wr_o   <= 1'b0;
            pc_val_o  <= PC_RST;
            ovf_wr_o  <= 1'b0;
            ovf_val_o <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            acc_wr_o <= 1'b0;
            pc_wr_o  <= 1'b0;
            ovf_wr_o <= 1'b0;
            done_o   <= finish;
            if (exec && opc != OPC_IRET) begin
                pc_wr_o  <= 1'b1;
                pc_val_o <= pc_i + (is_skip ? pc_step : PC_W'(1));
            end
            if (exec && opc == OPC_ROTATE) begin
                acc_wr_o  <= 1'b1;
                acc_val_o <= rotl(acc_i, fld_n);
            end else if (exec && opc == OPC_CMPL) begin
                acc_wr_o  <= 1'b1;
                acc_val_o <= ~acc_i + ACC_W'(1);
            end else if (state_reg == ST_IN_WAIT && wait_cnt_reg == 3'h1) begin
                acc_wr_o  <= 1'b1;
                acc_val_o <= din_s2;
            end else if (state_reg == ST_IRET && wait_cnt_reg == 3'h1) begin
                acc_wr_o  <= 1'b1;
                acc_val_o <= save_acc[fld_l];
                pc_wr_o   <= 1'b1;
                pc_val_o  <= save_pc[fld_l];
                ovf_wr_o  <= 1'b1;
                ovf_val_o <= save_ovf[fld_l];
            end
        end
    end

    // Direct I/O bus: address, function, data and strobes
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            io_addr_o             <= 4'h0;
            io_func_o             <= 4'h0;
            io_data_bus_o         <= ACC_RST;
            io_data_bus_oe_o      <= 1'b0;
            output_write_strobe_o <= 1'b0;
            input_read_strobe_o   <= 1'b0;
        end else begin
            io_data_bus_oe_o      <= exec && opc == OPC_OUT;
            output_write_strobe_o <= exec && opc == OPC_OUT;
            if (exec && (opc == OPC_OUT || opc == OPC_IN)) begin
                io_addr_o <= ir_reg[ADDR_LSB +: 4];
                io_func_o <= ir_reg[FUNC_LSB +: 4];
            end
            if (exec && opc == OPC_OUT) begin
                io_data_bus_o <= acc_i;
            end
            if (exec && opc == OPC_IN) begin
                input_read_strobe_o <= 1'b1;
            end else if (state_reg == ST_IN_DROP) begin
                input_read_strobe_o <= 1'b0;
            end
        end
    end

    // Interrupt levels: retained requests, mask, active levels
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg        <= 1'b0;
            pending_reg     <= LVL_RST;
            active_reg      <= LVL_RST;
            level_release_o <= LVL_RST;
            int_req_o       <= 1'b0;
        end else begin
            if (exec && opc == OPC_MASK) begin
                mask_reg <= 1'b1;
            end else if (exec && opc == OPC_UNMASK) begin
                mask_reg <= 1'b0;
            end
            // A request in the acknowledge cycle stays pending
            pending_reg <= (pending_reg & ~((int_ack_i ? LVL_N'(1) : LVL_N'(0))
                           << int_ack_level_i)) | irq_sync;
            level_release_o <= LVL_RST;
            if (int_ack_i) begin
                active_reg[int_ack_level_i] <= 1'b1;
            end
            if (state_reg == ST_IRET && wait_cnt_reg == 3'h1) begin
                active_reg[fld_l]      <= 1'b0;
                level_release_o[fld_l] <= 1'b1;
            end
            int_req_o <= !mask_reg && (pending_reg != LVL_RST) &&
                         !(exec && opc == OPC_MASK);
        end
    end

    // Context saved when a level enters service
    always_ff @(posedge clk_sys_i) begin
        if (int_ack_i) begin
            save_acc[int_ack_level_i] <= acc_i;
            save_pc[int_ack_level_i]  <= pc_i;
            save_ovf[int_ack_level_i] <= ovf_i;
        end
    end

    // Status outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o    <= 1'b1;
            halted_o   <= 1'b0;
            int_mask_o <= 1'b0;
        end else begin
            ready_o    <= (state_next == ST_IDLE);
            halted_o   <= (state_next == ST_HALT);
            int_mask_o <= (exec && opc == OPC_MASK) ? 1'b1 :
                          (exec && opc == OPC_UNMASK) ? 1'b0 : mask_reg;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_in_latch;
        acc_wr_o && input_read_strobe_o;
    endsequence
    sequence s_in_drop;
        !input_read_strobe_o && done_o;
    endsequence

    AST_ROTATE: assert property (exec && opc == OPC_ROTATE |=>
        acc_wr_o && acc_val_o == rotl($past(acc_i), $past(fld_n)))
        else $error("rotate result wrong");
    AST_HALT: assert property (exec && opc == OPC_HALT |=> halted_o && !ready_o)
        else $error("halt did not stop");
    AST_RESUME: assert property (state_reg == ST_HALT && run_rise |=> ##1 !halted_o)
        else $error("run did not resume");
    AST_SKIP_PC: assert property (exec && is_skip |=> pc_wr_o &&
        pc_val_o == $past(pc_i) + ($past(skip_take) ? PC_W'(2) : PC_W'(1)))
        else $error("skip PC step wrong");
    AST_SKIP_ZERO: assert property (exec && opc == OPC_SKIP_Z |=>
        pc_val_o == $past(pc_i) + (($past(acc_i) == 16'h0000) ? PC_W'(2) : PC_W'(1)))
        else $error("zero skip wrong");
    AST_SKIP_BIT: assert property (exec && opc == OPC_SKIP_BIT |=>
        pc_val_o == $past(pc_i) + ((($past(acc_i) << $past(fld_n)) >= 16'h8000) ?
        PC_W'(2) : PC_W'(1))) else $error("bit skip wrong");
    AST_SKIP_NOV: assert property (exec && opc == OPC_SKIP_NOV |=>
        pc_val_o == $past(pc_i) + ($past(ovf_i) ? PC_W'(1) : PC_W'(2)))
        else $error("overflow skip wrong");
    AST_TO_HALT: assert property (to_halt |=> halted_o)
        else $error("stop not reached");
    AST_RELEASE: assert property (level_release_o != LVL_RST |->
        (active_reg & level_release_o) == LVL_RST) else $error("released level still active");
    AST_CMPL: assert property (exec && opc == OPC_CMPL |=>
        acc_wr_o && (acc_val_o + $past(acc_i)) == ACC_RST)
        else $error("complement wrong");
    AST_OUT: assert property (exec && opc == OPC_OUT |=>
        output_write_strobe_o && io_data_bus_oe_o && io_data_bus_o == $past(acc_i)
        ##1 !output_write_strobe_o) else $error("output strobe wrong");
    AST_IN: assert property (exec && opc == OPC_IN |=>
        input_read_strobe_o[*4] ##1 s_in_latch ##1 s_in_drop)
        else $error("input sequence wrong");
    AST_IRET: assert property (exec && opc == OPC_IRET |=>
        !done_o[*3] ##1 (done_o && pc_wr_o && ovf_wr_o && level_release_o != LVL_RST))
        else $error("interrupt return timing wrong");
    AST_MASK: assert property (int_mask_o |-> !int_req_o)
        else $error("request while masked");
endmodule : misc_op_unit
`default_nettype wire

// >>> verif/io_periph_model.sv
/*
 * Behavioural peripheral on the direct I/O bus: stores words written to its
 * address and returns a word on reads, after a lag of 0 to 3 cycles.
 * Assumes address, function and strobes come from the unit's clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module io_periph_model #(
    parameter logic [3:0] MY_ADDR = 4'h5
) (
    input  wire logic        clk_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [3:0]  func_i,
    input  wire logic [15:0] cpu_data_i,
    input  wire logic        cpu_oe_i,
    input  wire logic        wr_stb_i,
    input  wire logic        rd_stb_i,
    input  wire logic [15:0] word_i,
    input  wire logic [1:0]  lag_i,
    output logic      [15:0] bus_o,
    output logic      [15:0] stored_o,
    output logic      [3:0]  func_o
);
    logic      [15:0] last_reg = 16'h0000;
    logic      [1:0]  wait_reg = 2'h0;
    wire logic        hit      = (addr_i == MY_ADDR);
    wire logic        drv      = rd_stb_i && hit && (wait_reg >= lag_i);
    // Store on the write strobe; count cycles of a read strobe for the lag
    always @(posedge clk_i) begin
        if (wr_stb_i && hit) begin
            stored_o <= cpu_data_i;
            func_o   <= func_i;
        end
        wait_reg <= (rd_stb_i && hit) ? wait_reg + {1'b0, wait_reg != 2'h3} : 2'h0;
        last_reg <= bus_o;
    end
    // Drive only while strobed; a released bus flips every cycle
    assign bus_o = drv ? word_i : (cpu_oe_i ? cpu_data_i : ~last_reg);
endmodule : io_periph_model
`default_nettype wire

// >>> verif/tb_top.sv
/*
 * Self-checking bench for the misc operation unit with one bus peripheral.
 * Assumes the unit's package and the peripheral model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import misc_op_pkg::*;
;
    logic             clk_sys_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0;
    logic             ovf_i = 1'b0, run_i = 1'b0, step_i = 1'b0, int_ack_i = 1'b0;
    logic [15:0]      instr_i = 16'h0000;
    logic [1:0]       ind_levels_i = 2'h0, p_lag = 2'h0;
    logic [ACC_W-1:0] acc_i = 16'h0000, p_word = 16'h0000;
    logic [PC_W-1:0]  pc_i = 12'h100;
    logic [LVL_N-1:0] irq_i = 8'h00;
    logic [LVL_W-1:0] int_ack_level_i = 3'h0;
    wire logic [15:0] io_data_bus_i;
    logic             ready_o, done_o, acc_wr_o, pc_wr_o, ovf_wr_o, ovf_val_o, halted_o;
    logic             io_data_bus_oe_o, output_write_strobe_o, input_read_strobe_o;
    logic             int_req_o, int_mask_o, got_ovf, got_oe;
    logic [ACC_W-1:0] acc_val_o, io_data_bus_o, p_stored, got_acc, got_od;
    logic [PC_W-1:0]  pc_val_o, got_pc;
    logic [3:0]       io_addr_o, io_func_o, p_func;
    logic [7:0]       got_af;
    logic [LVL_N-1:0] level_release_o, got_rel;
    int               err_total = 0, checked = 0, ndone = 0, cyc, acc_cyc;

    misc_op_unit dut (
        .clk_sys_i, .rst_i, .instr_valid_i, .instr_i, .ind_levels_i, .acc_i, .pc_i, .ovf_i,
        .run_i, .step_i, .irq_i, .int_ack_i, .int_ack_level_i, .io_data_bus_i, .ready_o,
        .done_o, .acc_wr_o, .acc_val_o, .pc_wr_o, .pc_val_o, .ovf_wr_o, .ovf_val_o, .halted_o,
        .io_addr_o, .io_func_o, .io_data_bus_o, .io_data_bus_oe_o, .output_write_strobe_o,
        .input_read_strobe_o, .int_req_o, .int_mask_o, .level_release_o
    );
    io_periph_model #(.MY_ADDR(4'h5)) periph (
        .clk_i(clk_sys_i), .addr_i(io_addr_o), .func_i(io_func_o),
        .cpu_data_i(io_data_bus_o), .cpu_oe_i(io_data_bus_oe_o),
        .wr_stb_i(output_write_strobe_o), .rd_stb_i(input_read_strobe_o),
        .word_i(p_word), .lag_i(p_lag), .bus_o(io_data_bus_i),
        .stored_o(p_stored), .func_o(p_func)
    );

    // Clock and a count of completions
    initial forever #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (done_o === 1'b1) ndone++;

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            err_total++;
            $display("MISMATCH t=%0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    // Offer one instruction, then record write-backs and bus activity
    task automatic exec(input logic [15:0] ins, input logic [1:0] k);
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b1;
        instr_i       <= ins;
        ind_levels_i  <= k;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b0;
        {got_acc, got_pc, got_ovf, got_od, got_oe, got_af} = 'x;
        got_rel = '0;
        // Counted as the edge at which each output is registered
        cyc = 1;
        do begin
            @(posedge clk_sys_i);
            #1;
            cyc++;
            if (acc_wr_o === 1'b1) {got_acc, acc_cyc} = {acc_val_o, cyc};
            if (pc_wr_o === 1'b1) got_pc = pc_val_o;
            if (ovf_wr_o === 1'b1) got_ovf = ovf_val_o;
            if (output_write_strobe_o === 1'b1) {got_od, got_oe} = {io_data_bus_o, io_data_bus_oe_o};
            if (output_write_strobe_o | input_read_strobe_o) got_af = {io_addr_o, io_func_o};
            got_rel = got_rel | level_release_o;
        end while (done_o !== 1'b1 && halted_o !== 1'b1 && cyc < 20);
    endtask : exec

    task automatic t_rotate();
        logic [3:0]  n;
        logic [31:0] t;
        for (int i = 0; i < 4; i++) begin
            n = (i == 3) ? 4'hF : 4'(i * 2);
            @(posedge clk_sys_i);
            acc_i <= 16'hC00B;
            exec({OPC_ROTATE, 4'h0, n}, 2'(i % 3));
            t = {16'hC00B, 16'hC00B} << n;
            chk_val(got_acc, t[31:16]);
            chk_cnt(cyc, 2 + i % 3);
        end
    endtask : t_rotate

    task automatic t_skips();
        logic [15:0] ins [9];
        logic [15:0] acc [9];
        logic [8:0]  ovf, skp;
        ins = '{{OPC_SKIP_Z, 8'h00}, {OPC_SKIP_Z, 8'h00}, {OPC_SKIP_NZ, 8'h00},
                {OPC_SKIP_NZ, 8'h00}, {OPC_SKIP_BIT, 8'h00}, {OPC_SKIP_BIT, 8'h0F},
                {OPC_SKIP_BIT, 8'h00}, {OPC_SKIP_NOV, 8'h00}, {OPC_SKIP_NOV, 8'h00}};
        acc = '{16'h0000, 16'h0100, 16'h0000, 16'h0001, 16'h8000, 16'h0001,
                16'h0001, 16'hFFFF, 16'h0000};
        ovf = 9'b100000000;
        skp = 9'b010111001;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys_i);
            acc_i <= acc[i];
            ovf_i <= ovf[i];
            exec(ins[i], 2'h0);
            chk_val(got_pc, pc_i + (skp[i] ? 12'h002 : 12'h001));
        end
    endtask : t_skips

    task automatic t_cmpl();
        logic [15:0] v [4];
        v = '{16'h0001, 16'h0000, 16'h8000, 16'h1234};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            acc_i <= v[i];
            exec({OPC_CMPL, 8'h00}, 2'h0);
            chk_val(got_acc, ~v[i] + 16'h0001);
            chk_cnt(cyc, 2);
        end
    endtask : t_cmpl

    task automatic t_output();
        @(posedge clk_sys_i);
        acc_i <= 16'hA5C3;
        exec({OPC_OUT, 4'h5, 4'h9}, 2'h0);
        chk_val(got_od, 16'hA5C3);
        chk_val({got_oe, got_af}, 16'h0159);
        @(posedge clk_sys_i);
        acc_i <= 16'h0F0F;
        exec({OPC_OUT, 4'h6, 4'h2}, 2'h0);
        chk_val(got_af, 16'h0062);
        @(posedge clk_sys_i);
        #1;
        chk_val(p_stored, 16'hA5C3);
        chk_val({12'h000, p_func}, 16'h0009);
    endtask : t_output

    task automatic t_input();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_i);
            p_word <= i ? 16'hFEDC : 16'h1234;
            p_lag  <= 2'(1 - i);
            exec({OPC_IN, 4'h5, 4'h3}, 2'(i));
            chk_cnt(cyc, 7 + i);
            chk_val(got_af, 16'h0053);
            chk_val(got_acc, i ? 16'hFEDC : 16'h1234);
            chk_cnt(acc_cyc, 6 + i);
            chk_val(input_read_strobe_o, 1'b0);
        end
    endtask : t_input

    task automatic t_irq();
        exec({OPC_MASK, 8'h00}, 2'h0);
        chk_val(int_mask_o, 1'b1);
        @(posedge clk_sys_i);
        irq_i <= 8'h08;
        repeat (8) @(posedge clk_sys_i);
        // Request gone before unmask: only a retained one can raise the line
        irq_i <= 8'h00;
        #1;
        chk_val(int_req_o, 1'b0);
        exec({OPC_UNMASK, 8'h00}, 2'h0);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk_val(int_req_o, 1'b1);
        @(posedge clk_sys_i);
        irq_i <= 8'h00;
        repeat (4) @(posedge clk_sys_i);
        {int_ack_i, int_ack_level_i, acc_i, pc_i, ovf_i} <= {1'b1, 3'h3, 16'hBEEF, 12'h123, 1'b1};
        @(posedge clk_sys_i);
        {int_ack_i, acc_i, pc_i, ovf_i} <= {1'b0, 16'h0000, 12'h100, 1'b0};
        exec({OPC_IRET, 3'h0, 3'h3, 2'h0}, 2'h1);
        chk_cnt(cyc, 6);
        chk_val({got_ovf, got_pc}, 16'h1123);
        chk_val(got_acc, 16'hBEEF);
        chk_val(got_rel, 16'h0008);
    endtask : t_irq

    task automatic t_halt();
        int n0;
        exec({OPC_HALT, 8'h00}, 2'h0);
        chk_val(halted_o, 1'b1);
        n0 = ndone;
        @(posedge clk_sys_i);
        {instr_valid_i, instr_i} <= {1'b1, OPC_CMPL, 8'h00};
        repeat (12) @(posedge clk_sys_i);
        chk_cnt(ndone - n0, 0);
        step_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        step_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk_cnt(ndone - n0, 1);
        chk_val(halted_o, 1'b1);
        @(posedge clk_sys_i);
        run_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        run_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk_val(halted_o, 1'b0);
        chk_cnt(int'(ndone - n0 > 3), 1);
    endtask : t_halt

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Main sequence after a six-cycle reset
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        chk_val({ready_o, halted_o, done_o}, 16'h0004);
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_rotate();
        t_skips();
        t_cmpl();
        t_output();
        t_input();
        t_irq();
        t_halt();
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        err_total++;
        results();
    end
endmodule : tb_top
`default_nettype wire
